// ==== kiu_pkg.sv ====
package kiu_pkg;
  localparam int unsigned KIU_NPINS    = 5;
  // register byte addresses
  localparam logic [11:0] KIU_OFS_CTRL = 12'h000;
  localparam logic [11:0] KIU_OFS_EN   = 12'h004;
  // keypad_status_control fields
  localparam int unsigned KIU_BIT_MODE = 0;
  localparam int unsigned KIU_BIT_MASK = 1;
  localparam int unsigned KIU_BIT_ACK  = 2;
  localparam int unsigned KIU_BIT_FLAG = 3;
  localparam logic [4:0]  KIU_EN_RST   = 5'h00;
  localparam logic [15:0] KIU_VEC_HI   = 16'hffde;
  localparam logic [15:0] KIU_VEC_LO   = 16'hffdf;
endpackage

// ==== kiu_keypad_irq_unit.sv ====
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module kiu_keypad_irq_unit #(
  parameter int unsigned NPINS = kiu_pkg::KIU_NPINS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPINS-1:0]  key_pin_in,
  input  wire logic [NPINS-1:0]  port_dir_out,
  output logic      [NPINS-1:0]  key_pin_oe_mask,
  output logic      [NPINS-1:0]  key_pullup_en,
  input  wire logic              vector_fetch,
  output logic                   cpu_irq_req,
  output logic                   wake_req,
  output logic      [15:0]       irq_vector_addr
);
  import kiu_pkg::*;

  logic [NPINS-1:0] pin_irq_enable_bits_q;
  logic             level_sense_select_q;
  logic             irq_mask_q;
  logic             irq_pending_flag_q;
  logic [NPINS-1:0] sync1_q, sync2_q;
  logic             all_high_prev_q;
  logic             ack_seen_q;
  logic             all_high, any_low, fall_evt, ack, wr, rd, hit_ctrl, hit_en;

  assign wr       = psel && penable && pwrite;
  assign rd       = psel && !pwrite;
  assign hit_ctrl = paddr == KIU_OFS_CTRL;
  assign hit_en   = paddr == KIU_OFS_EN;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(hit_ctrl || hit_en);

  // two-stage synchroniser; first stage only feeds the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= key_pin_in;
      sync2_q <= sync1_q;
    end
  end

  // disabled pins count as high so they never block or trigger
  assign all_high = &(sync2_q | ~pin_irq_enable_bits_q);
  assign any_low  = !all_high;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) all_high_prev_q <= 1'b1;
    else          all_high_prev_q <= all_high;
  end

  // fires once when the enabled set leaves all-high; a second pin
  // falling while one is low is not seen
  assign fall_evt = all_high_prev_q && any_low;
  assign ack = vector_fetch || (wr && hit_ctrl && pwdata[KIU_BIT_ACK]);

  // level mode: an ack taken while a pin is low is remembered, so the
  // request still clears when the pins come back high afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_seen_q <= 1'b0;
    end else if (fall_evt || !level_sense_select_q || all_high) begin
      ack_seen_q <= 1'b0;
    end else if (ack) begin
      ack_seen_q <= 1'b1;
    end
  end

  // set beats clear; level mode re-asserts while any enabled pin stays low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pending_flag_q <= 1'b0;
    end else if (fall_evt) begin
      irq_pending_flag_q <= 1'b1;
    end else if (level_sense_select_q && any_low) begin
      irq_pending_flag_q <= 1'b1;
    end else if (ack || (level_sense_select_q && ack_seen_q)) begin
      irq_pending_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_sense_select_q <= 1'b0;
      irq_mask_q           <= 1'b0;
    end else if (wr && hit_ctrl) begin
      level_sense_select_q <= pwdata[KIU_BIT_MODE];
      irq_mask_q           <= pwdata[KIU_BIT_MASK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_irq_enable_bits_q <= KIU_EN_RST;
    else if (wr && hit_en) pin_irq_enable_bits_q <= pwdata[NPINS-1:0];
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd && hit_ctrl) begin
      prdata[KIU_BIT_MODE] = level_sense_select_q;
      prdata[KIU_BIT_MASK] = irq_mask_q;
      prdata[KIU_BIT_FLAG] = irq_pending_flag_q;
      // ack bit left at zero: write-only
    end else if (rd && hit_en) begin
      prdata[NPINS-1:0] = pin_irq_enable_bits_q;
    end
  end

  assign cpu_irq_req     = irq_pending_flag_q && !irq_mask_q;
  assign wake_req        = cpu_irq_req;
  assign irq_vector_addr = KIU_VEC_HI;
  assign key_pullup_en   = pin_irq_enable_bits_q;
  // port drivers: output only when direction set and not a key input
  assign key_pin_oe_mask = port_dir_out & ~pin_irq_enable_bits_q;

  property p_edge_latch;
    @(posedge pclk) disable iff (!presetn) fall_evt |=> irq_pending_flag_q;
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");

  property p_edge_ack;
    @(posedge pclk) disable iff (!presetn)
      (ack && !fall_evt && !level_sense_select_q) |=> !irq_pending_flag_q;
  endproperty
  a_edge_ack: assert property (p_edge_ack) else $error("ack did not clear");

  property p_level_hold;
    @(posedge pclk) disable iff (!presetn)
      (level_sense_select_q && any_low) |=> irq_pending_flag_q;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level not held");

  property p_no_spurious;
    @(posedge pclk) disable iff (!presetn)
      (!irq_pending_flag_q && !fall_evt && !(level_sense_select_q && any_low))
      |=> !irq_pending_flag_q;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("spurious set");

  property p_mask;
    @(posedge pclk) disable iff (!presetn) cpu_irq_req |-> !irq_mask_q && irq_pending_flag_q;
  endproperty
  a_mask: assert property (p_mask) else $error("mask ignored");

  property p_ack_reads_zero;
    @(posedge pclk) disable iff (!presetn) (rd && hit_ctrl) |-> !prdata[KIU_BIT_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack read one");

  property p_override;
    @(posedge pclk) disable iff (!presetn)
      (key_pin_oe_mask & pin_irq_enable_bits_q) == '0;
  endproperty
  a_override: assert property (p_override) else $error("enabled pin driven");

  property p_pullup;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_en) |=> key_pullup_en == $past(pwdata[NPINS-1:0]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup mismatch");

  property p_wake;
    @(posedge pclk) disable iff (!presetn) wake_req == cpu_irq_req;
  endproperty
  a_wake: assert property (p_wake) else $error("wake mismatch");

  property p_sync_in;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn)
      |-> sync1_q == $past(key_pin_in);
  endproperty
  a_sync_in: assert property (p_sync_in) else $error("sync stage one wrong");

  property p_sync_chain;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn)
      |-> sync2_q == $past(sync1_q);
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("sync stage two wrong");

  property p_arm_prev;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn)
      |-> all_high_prev_q == $past(all_high);
  endproperty
  a_arm_prev: assert property (p_arm_prev) else $error("arming not previous");

  property p_fall_pulse;
    @(posedge pclk) disable iff (!presetn)
      fall_evt
      |=> !fall_evt;
  endproperty
  a_fall_pulse: assert property (p_fall_pulse) else $error("edge event too long");

  property p_flag_read;
    @(posedge pclk) disable iff (!presetn)
      (rd && hit_ctrl)
      |-> prdata[KIU_BIT_FLAG] == irq_pending_flag_q;
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

  property p_mode_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_ctrl)
      |=> level_sense_select_q == $past(pwdata[KIU_BIT_MODE]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not written");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_ctrl)
      |=> irq_mask_q == $past(pwdata[KIU_BIT_MASK]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_en_no_trig;
    @(posedge pclk) disable iff (!presetn)
      (pin_irq_enable_bits_q == '0)
      |-> !fall_evt;
  endproperty
  a_en_no_trig: assert property (p_en_no_trig) else $error("disabled pin fired");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (wr && !hit_ctrl && !hit_en)
      |=> $stable(pin_irq_enable_bits_q) && $stable(irq_mask_q);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write landed");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (irq_pending_flag_q && !ack && !ack_seen_q)
      |=> irq_pending_flag_q;
  endproperty
  a_hold: assert property (p_hold) else $error("request lost without ack");

  property p_ack_remember;
    @(posedge pclk) disable iff (!presetn)
      (level_sense_select_q && any_low && ack && !fall_evt)
      |=> ack_seen_q;
  endproperty
  a_ack_remember: assert property (p_ack_remember) else $error("ack forgotten");

  property p_level_clear;
    @(posedge pclk) disable iff (!presetn)
      (level_sense_select_q && all_high && (ack || ack_seen_q))
      |=> !irq_pending_flag_q;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("level not cleared");

  property p_vector;
    @(posedge pclk) disable iff (!presetn)
      cpu_irq_req
      |-> irq_vector_addr == KIU_VEC_HI;
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable)
      |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access stalled");

  c_edge:  cover property (@(posedge pclk) disable iff (!presetn) fall_evt ##1 ack);
  c_ackfirst: cover property (@(posedge pclk) disable iff (!presetn)
                              ack_seen_q ##1 !irq_pending_flag_q);
  c_fetch: cover property (@(posedge pclk) disable iff (!presetn)
                           vector_fetch && irq_pending_flag_q);
  c_level: cover property (@(posedge pclk) disable iff (!presetn)
                           level_sense_select_q && any_low && ack);
  c_irq:   cover property (@(posedge pclk) disable iff (!presetn) $rose(cpu_irq_req));
endmodule

// ==== kiu_keys.sv ====
`timescale 1ns/1ps
// keys to ground on the shared pins; a released pin floats unless pulled up
module kiu_keys (
  input  wire logic       pclk,
  input  wire logic [4:0] key_press,
  input  wire logic [4:0] key_pullup_en,
  output logic      [4:0] key_pin_in
);
  logic t_q;
  initial t_q = 1'b0;
  // floating pin toggles so an unknown is never read as a stable level
  always @(posedge pclk) t_q <= ~t_q;
  assign key_pin_in = ~key_press & (key_pullup_en | {5{t_q}});
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import kiu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, vector_fetch, pready, pslverr;
  logic        cpu_irq_req, wake_req, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  key_pin_in, port_dir_out, key_pin_oe_mask, key_pullup_en, key_press;
  logic [15:0] irq_vector_addr;
  int          err_count, checked;
  kiu_keypad_irq_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .key_pin_in, .port_dir_out, .key_pin_oe_mask,
    .key_pullup_en, .vector_fetch, .cpu_irq_req, .wake_req, .irq_vector_addr);
  kiu_keys keys_u (.pclk, .key_press, .key_pullup_en, .key_pin_in);
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // trailing idle edge keeps two requests from sharing a time step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    cyc(5000);
    err_count++;
    wrap_up;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    vector_fetch = 0; key_press = 0; port_dir_out = 5'h1f; err_count = 0; checked = 0;
    cyc(12);
    presetn <= 1;
    cyc(1);
    rdchk(KIU_OFS_CTRL, 0);
    rdchk(KIU_OFS_EN, 0);
    chk(key_pin_oe_mask, 5'h1f);
    apb(1, KIU_OFS_EN, 32'hff);
    rdchk(KIU_OFS_EN, 32'h1f);
    chk(key_pullup_en, 5'h1f);
    chk(key_pin_oe_mask, 0);
    key_press <= 5'h01;
    cyc(4);
    rdchk(KIU_OFS_CTRL, 32'h8);
    chk(cpu_irq_req, 1);
    chk(wake_req, 1);
    chk(irq_vector_addr, 16'hffde);
    apb(1, KIU_OFS_CTRL, 32'h4);
    rdchk(KIU_OFS_CTRL, 0);
    key_press <= 5'h03;
    cyc(4);
    rdchk(KIU_OFS_CTRL, 0);
    key_press <= 0;
    cyc(4);
    key_press <= 5'h04;
    cyc(4);
    chk(cpu_irq_req, 1);
    vector_fetch <= 1;
    cyc(1);
    vector_fetch <= 0;
    cyc(2);
    chk(cpu_irq_req, 0);
    key_press <= 0;
    apb(1, KIU_OFS_CTRL, 32'h2);
    cyc(4);
    key_press <= 5'h10;
    cyc(4);
    rdchk(KIU_OFS_CTRL, 32'ha);
    chk(cpu_irq_req, 0);
    apb(1, KIU_OFS_CTRL, 32'h5);
    rdchk(KIU_OFS_CTRL, 32'h9);
    chk(cpu_irq_req, 1);
    key_press <= 0;
    cyc(4);
    rdchk(KIU_OFS_CTRL, 32'h9);
    apb(1, KIU_OFS_CTRL, 32'h5);
    rdchk(KIU_OFS_CTRL, 32'h1);
    key_press <= 5'h10;
    cyc(4);
    apb(1, KIU_OFS_CTRL, 32'h5);
    rdchk(KIU_OFS_CTRL, 32'h9);
    key_press <= 0;
    cyc(4);
    rdchk(KIU_OFS_CTRL, 32'h1);
    key_press <= 5'h01;
    cyc(4);
    presetn <= 0;
    cyc(2);
    presetn <= 1;
    cyc(1);
    rdchk(KIU_OFS_CTRL, 0);
    apb(1, 12'h008, 32'hff);
    chk(se, 1);
    rdchk(12'h008, 0);
    wrap_up;
  end
endmodule
